/* File: src/keyed_watchdog_timer.sv */
// Keyed watchdog timer with APB registers and reset outputs
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "keyed_watchdog_params.svh"
module keyed_watchdog_timer #(
  parameter int CNT_W = 18
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysClockLevel,
  input wire logic lowRcLevel,
  input wire logic lowXtalLevel,
  input wire logic [1:0] powerMode,
  output logic deviceReset,
  output logic pcSpReset,
  output logic wakeUp,
  output logic irq
);
  logic [7:0] control_q;
  logic [2:0] config_q;
  logic keyFault_q;
  logic idleKeep_q;
  logic timeoutFlag_q;
  logic powerDown_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [CNT_W-1:0] count_q;
  logic [1:0] sysDiv_q;
  logic [1:0] faultCnt_q;
  keyed_watchdog_pkg::fault_state_e fault_q;
  logic [31:0] rdata_d;
  logic sysRise, rcRise, xtalRise, subTick, baseTick, tick;
  logic wr, rd, clearCmd, haltCmd, expire, keyLegal, wdtOn, lowPower, fire;
  logic [4:0] key;
  logic [CNT_W-1:0] ratioLast;
  logic [3:0] [7:0] wbytes;

  wdt_edge_detect u_sys (.clock(clock), .rst(rst), .level(sysClockLevel), .rise(sysRise));
  wdt_edge_detect u_rc (.clock(clock), .rst(rst), .level(lowRcLevel), .rise(rcRise));
  wdt_edge_detect u_xtal (.clock(clock), .rst(rst), .level(lowXtalLevel), .rise(xtalRise));

  assign wbytes = pwdata;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign key = control_q[`WDT_KEY_MSB:`WDT_KEY_LSB];
  assign clearCmd = wr && paddr == `WDT_ADDR_EVENT && pwdata[`WDT_EV_CLEAR];
  assign haltCmd = wr && paddr == `WDT_ADDR_EVENT && pwdata[`WDT_EV_HALT];
  assign keyLegal = key == `WDT_KEY_ENABLE || key == `WDT_KEY_DISABLE;
  // Always-enabled option ignores the disable key
  assign wdtOn = keyLegal && (config_q[`WDT_CFG_ALWAYS] || key == `WDT_KEY_ENABLE);
  assign lowPower = powerMode == keyed_watchdog_pkg::MODE_IDLE || powerMode == keyed_watchdog_pkg::MODE_SLEEP;
  assign subTick = config_q[`WDT_CFG_SUB_XTAL] ? xtalRise : rcRise;
  // System clock input is whatever currently drives the core, so rate follows it
  assign baseTick = sysRise && sysDiv_q == `WDT_SYSDIV_LAST;
  assign tick = config_q[`WDT_CFG_USE_SUB] ? subTick : baseTick;

  always_comb begin
    case (control_q[`WDT_SEL_MSB:`WDT_SEL_LSB])
      3'h0: ratioLast = CNT_W'((1 << `WDT_LOG_SEL0) - 1);
      3'h1: ratioLast = CNT_W'((1 << `WDT_LOG_SEL1) - 1);
      3'h2: ratioLast = CNT_W'((1 << `WDT_LOG_SEL2) - 1);
      3'h3: ratioLast = CNT_W'((1 << `WDT_LOG_SEL3) - 1);
      3'h4: ratioLast = CNT_W'((1 << `WDT_LOG_SEL4) - 1);
      3'h5: ratioLast = CNT_W'((1 << `WDT_LOG_SEL5) - 1);
      3'h6: ratioLast = CNT_W'((1 << `WDT_LOG_SEL6) - 1);
      default: ratioLast = CNT_W'((1 << `WDT_LOG_SEL7) - 1);
    endcase
  end
  assign expire = wdtOn && tick && count_q == ratioLast;
  assign fire = fault_q == keyed_watchdog_pkg::FAULT_FIRE;

  always_ff @(posedge clock) begin
    if (rst) begin
      sysDiv_q <= 2'h0;
    end else if (sysRise) begin
      sysDiv_q <= sysDiv_q + 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || fire || clearCmd || haltCmd || !wdtOn || expire) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  // Fault counts low RC edges so the reset lands 1 to 2 of its cycles late
  always_ff @(posedge clock) begin
    if (rst) begin
      fault_q <= keyed_watchdog_pkg::FAULT_IDLE;
      faultCnt_q <= 2'h0;
    end else begin
      case (fault_q)
        keyed_watchdog_pkg::FAULT_IDLE: begin
          faultCnt_q <= 2'h0;
          if (!keyLegal) begin
            fault_q <= keyed_watchdog_pkg::FAULT_WAIT;
          end
        end
        keyed_watchdog_pkg::FAULT_WAIT: begin
          if (rcRise) begin
            faultCnt_q <= faultCnt_q + 2'h1;
            if (faultCnt_q + 2'h1 == `WDT_FAULT_RC_EDGES) begin
              fault_q <= keyed_watchdog_pkg::FAULT_FIRE;
            end
          end
        end
        keyed_watchdog_pkg::FAULT_FIRE: fault_q <= keyed_watchdog_pkg::FAULT_IDLE;
        default: fault_q <= keyed_watchdog_pkg::FAULT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || fire) begin
      control_q <= `WDT_CONTROL_RESET;
    end else if (wr && paddr == `WDT_ADDR_CONTROL && pstrb[0]) begin
      control_q <= wbytes[0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      config_q <= 3'h0;
    end else if (wr && paddr == `WDT_ADDR_CONFIG && pstrb[0]) begin
      config_q <= pwdata[2:0];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      keyFault_q <= 1'b0;
      idleKeep_q <= 1'b0;
    end else begin
      if (fire) begin
        keyFault_q <= 1'b1;
      end else if (wr && paddr == `WDT_ADDR_SYSFLAGS && pstrb[0] && !pwdata[`WDT_BIT_KEYFAULT]) begin
        keyFault_q <= 1'b0;
      end
      if (wr && paddr == `WDT_ADDR_SYSFLAGS && pstrb[0]) begin
        idleKeep_q <= pwdata[`WDT_BIT_IDLEKEEP];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timeoutFlag_q <= 1'b0;
      powerDown_q <= 1'b0;
    end else if (expire) begin
      timeoutFlag_q <= 1'b1;
      powerDown_q <= lowPower ? 1'b1 : powerDown_q;
    end else if (haltCmd) begin
      timeoutFlag_q <= 1'b0;
      powerDown_q <= 1'b1;
    end else if (clearCmd) begin
      powerDown_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      deviceReset <= 1'b0;
      pcSpReset <= 1'b0;
      wakeUp <= 1'b0;
    end else begin
      deviceReset <= fire || (expire && !lowPower);
      pcSpReset <= expire && lowPower;
      wakeUp <= expire && lowPower;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= 3'h0;
      mask_q <= 3'h0;
    end else begin
      status_q[`WDT_ST_KEYFAULT] <= fire | (status_q[`WDT_ST_KEYFAULT] &
        ~(wr && paddr == `WDT_ADDR_STATUS && pwdata[`WDT_ST_KEYFAULT]));
      status_q[`WDT_ST_EXPIRE] <= expire | (status_q[`WDT_ST_EXPIRE] &
        ~(wr && paddr == `WDT_ADDR_STATUS && pwdata[`WDT_ST_EXPIRE]));
      status_q[`WDT_ST_WAKE] <= (expire && lowPower) | (status_q[`WDT_ST_WAKE] &
        ~(wr && paddr == `WDT_ADDR_STATUS && pwdata[`WDT_ST_WAKE]));
      if (wr && paddr == `WDT_ADDR_IRQ_MASK && pstrb[0]) begin
        mask_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    case (paddr)
      `WDT_ADDR_CONTROL: rdata_d = {24'h0, control_q};
      `WDT_ADDR_SYSFLAGS: rdata_d = {24'h0, idleKeep_q, 6'h0, keyFault_q};
      `WDT_ADDR_STATUS: rdata_d = {29'h0, status_q};
      `WDT_ADDR_IRQ_MASK: rdata_d = {29'h0, mask_q};
      `WDT_ADDR_CONFIG: rdata_d = {29'h0, config_q};
      `WDT_ADDR_EVENT: rdata_d = {26'h0, wdtOn, powerDown_q, timeoutFlag_q, 3'h0};
      default: rdata_d = 32'h0;
    endcase
  end

  // Answer in the first access cycle; addresses above WDT_ADDR_EVENT flag an error
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rdata_d;
      pslverr <= psel && !penable && paddr > `WDT_ADDR_EVENT;
    end
  end

  property p_fault_flag;
    @(posedge clock) disable iff (rst) fire |=> keyFault_q && deviceReset;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("key fault flag or reset missing");

  property p_flag_sticky;
    @(posedge clock) disable iff (rst) keyFault_q && !wr |=> keyFault_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("fault flag dropped by hardware");

  property p_norm_timeout;
    @(posedge clock) disable iff (rst) expire && !lowPower |=> deviceReset && timeoutFlag_q && !pcSpReset;
  endproperty
  a_norm_timeout: assert property (p_norm_timeout) else $error("normal time-out wrong");

  property p_low_timeout;
    @(posedge clock) disable iff (rst) expire && lowPower |=> pcSpReset && wakeUp && powerDown_q && !deviceReset;
  endproperty
  a_low_timeout: assert property (p_low_timeout) else $error("low power time-out wrong");

  property p_clear;
    @(posedge clock) disable iff (rst) clearCmd || haltCmd |=> count_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_disabled;
    @(posedge clock) disable iff (rst) key == `WDT_KEY_DISABLE && !config_q[`WDT_CFG_ALWAYS]
      |=> count_q == '0 && !pcSpReset;
  endproperty
  a_disabled: assert property (p_disabled) else $error("time-out while disabled");

  // Counted apart from the state machine so the check does not copy it
  logic [1:0] rcSeen_q;
  always_ff @(posedge clock) begin
    if (rst || fault_q == keyed_watchdog_pkg::FAULT_IDLE) begin
      rcSeen_q <= 2'h0;
    end else if (rcRise && rcSeen_q != 2'h3) begin
      rcSeen_q <= rcSeen_q + 2'h1;
    end
  end

  sequence s_fault_start;
    fault_q == keyed_watchdog_pkg::FAULT_IDLE && !keyLegal;
  endsequence
  sequence s_fault_wait;
    fault_q == keyed_watchdog_pkg::FAULT_WAIT && rcSeen_q == 2'h0 && !fire;
  endsequence
  property p_fault_delay;
    @(posedge clock) disable iff (rst) s_fault_start |=> s_fault_wait;
  endproperty
  a_fault_delay: assert property (p_fault_delay) else $error("fault reset too early");

  property p_fault_edges;
    @(posedge clock) disable iff (rst) fire |-> rcSeen_q == `WDT_FAULT_RC_EDGES;
  endproperty
  a_fault_edges: assert property (p_fault_edges) else $error("fault reset not on second RC edge");

  property p_pd_keep;
    @(posedge clock) disable iff (rst) expire && !lowPower |=> powerDown_q == $past(powerDown_q);
  endproperty
  a_pd_keep: assert property (p_pd_keep) else $error("power-down flag changed");
endmodule

/* File: inc/keyed_watchdog_params.svh */
// Constants for the keyed watchdog timer
`ifndef KEYED_WATCHDOG_PARAMS_SVH
`define KEYED_WATCHDOG_PARAMS_SVH
`define WDT_ADDR_CONTROL 12'h000
`define WDT_ADDR_SYSFLAGS 12'h004
`define WDT_ADDR_STATUS 12'h008
`define WDT_ADDR_IRQ_MASK 12'h00c
`define WDT_ADDR_CONFIG 12'h010
`define WDT_ADDR_EVENT 12'h014
`define WDT_CONTROL_RESET 8'h53
`define WDT_KEY_MSB 7
`define WDT_KEY_LSB 3
`define WDT_SEL_MSB 2
`define WDT_SEL_LSB 0
`define WDT_KEY_ENABLE 5'h0a
`define WDT_KEY_DISABLE 5'h15
`define WDT_FAULT_RC_EDGES 2'h2
`define WDT_LOG_SEL0 8
`define WDT_LOG_SEL1 10
`define WDT_LOG_SEL2 12
`define WDT_LOG_SEL3 14
`define WDT_LOG_SEL4 15
`define WDT_LOG_SEL5 16
`define WDT_LOG_SEL6 17
`define WDT_LOG_SEL7 18
`define WDT_SYSDIV_LAST 2'h3
`define WDT_BIT_KEYFAULT 0
`define WDT_BIT_IDLEKEEP 7
`define WDT_ST_TIMEOUT 0
`define WDT_ST_POWERDOWN 1
`define WDT_ST_KEYFAULT 0
`define WDT_ST_EXPIRE 1
`define WDT_ST_WAKE 2
`define WDT_CFG_ALWAYS 0
`define WDT_CFG_USE_SUB 1
`define WDT_CFG_SUB_XTAL 2
`define WDT_EV_CLEAR 0
`define WDT_EV_HALT 1
`endif

/* File: inc/keyed_watchdog_pkg.sv */
// Types for the keyed watchdog timer
package keyed_watchdog_pkg;
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLOW,
    MODE_IDLE,
    MODE_SLEEP
  } power_mode_e;
  typedef enum logic [1:0] {
    FAULT_IDLE,
    FAULT_WAIT,
    FAULT_FIRE
  } fault_state_e;
endpackage

/* File: src/wdt_edge_detect.sv */
// Rising edge detector for a sampled clock level
`timescale 1ns/1ps
module wdt_edge_detect (
  input wire logic clock,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  logic prev_q;
  // Held high in reset so a level already up gives no false edge
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level;
    end
  end
  assign rise = level & ~prev_q;
endmodule

/* File: bench/keyed_watchdog_timer_tb_top.sv */
// Self-checking bench for the keyed watchdog timer
`timescale 1ns/1ps
`include "keyed_watchdog_params.svh"
module keyed_watchdog_timer_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, deviceReset, pcSpReset, wakeUp, irq;
  logic sysClockLevel = 1'b0;
  logic lowRcLevel = 1'b0;
  logic lowXtalLevel = 1'b0;
  logic sysSlow = 1'b0;
  logic [1:0] powerMode = 2'h0;
  logic [7:0] cyc = 8'h00;
  logic [31:0] seed = 32'heec8;
  int errTotal = 0;
  int testsRun = 0;
  always #25 clock = ~clock;
  // Level inputs kept well below clock/2 so every edge is seen
  always @(posedge clock) begin
    cyc <= cyc + 8'h01;
    lowRcLevel <= cyc[1];
    lowXtalLevel <= cyc[2];
    sysClockLevel <= sysSlow ? cyc[2] : cyc[1];
  end
  keyed_watchdog_timer #(.CNT_W(18)) keyed_watchdog_timer_i (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysClockLevel(sysClockLevel), .lowRcLevel(lowRcLevel),
    .lowXtalLevel(lowXtalLevel), .powerMode(powerMode), .deviceReset(deviceReset), .pcSpReset(pcSpReset),
    .wakeUp(wakeUp), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int rlog(input logic [2:0] s);
    return (s < 3'h3) ? 8 + 2 * s : 11 + s;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready_wait", 1, n);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r & m);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    powerMode <= 2'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
  endtask
  task automatic wait_pulse(input int lim, output int n);
    n = 0;
    while (deviceReset !== 1'b1 && pcSpReset !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  // Timing window allows two ticks of slack below the ratio and one tick above it
  task automatic run_to(input string name, input logic [2:0] cfg, input logic [4:0] key, input logic [2:0] sel,
                        input int tp, input logic [1:0] mode, input logic fire, input int pre);
    int ex, n;
    logic slp;
    ex = tp << rlog(sel);
    slp = mode[1];
    do_reset();
    wr(`WDT_ADDR_CONFIG, {29'h0, cfg});
    wr(`WDT_ADDR_CONTROL, {seed[31:8], key, sel});
    seed = xs(seed);
    wr(`WDT_ADDR_EVENT, slp ? 32'h2 : 32'h1);
    powerMode <= mode;
    if (pre > 0) begin
      repeat (pre) @(posedge clock);
      wr(`WDT_ADDR_EVENT, 32'h1);
    end
    wait_pulse(ex + tp + 40, n);
    chk("fire_window", fire, (n >= ex - 2 * tp - 8) && (n < ex + tp + 40));
    chk("device_reset", fire & ~slp, deviceReset);
    chk("pc_sp_reset", fire & slp, pcSpReset);
    chk("wake_up", fire & slp, wakeUp);
    rd(`WDT_ADDR_EVENT, 32'h18, {27'h0, fire & slp, fire, 3'h0}, "timeout_pd_flags");
    rd(`WDT_ADDR_STATUS, 32'h6, {29'h0, fire & slp, fire, 1'b0}, "status_bits");
    $display("test %s done", name);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, about twice the expected run
  initial begin
    #5000000;
    errTotal++;
    $display("MISMATCH run_time expected done seen hang");
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    logic [4:0] key;
    do_reset();
    rd(`WDT_ADDR_CONTROL, 32'hff, 32'h53, "control_reset");
    rd(`WDT_ADDR_EVENT, 32'h20, 32'h20, "running_after_reset");
    rd(`WDT_ADDR_SYSFLAGS, 32'h81, 32'h0, "sysflags_reset");
    for (int s = 0; s < 8; s++) begin
      wr(`WDT_ADDR_CONTROL, {24'h0, `WDT_KEY_ENABLE, s[2:0]});
      rd(`WDT_ADDR_CONTROL, 32'hff, {24'h0, `WDT_KEY_ENABLE, s[2:0]}, "select_rw");
    end
    wr(`WDT_ADDR_CONTROL, {24'h0, `WDT_KEY_DISABLE, 3'h5});
    rd(`WDT_ADDR_EVENT, 32'h20, 32'h0, "stopped_by_key");
    wr(`WDT_ADDR_SYSFLAGS, {24'h0, seed[7], 7'h0});
    rd(`WDT_ADDR_SYSFLAGS, 32'h80, {24'h0, seed[7], 7'h0}, "idle_keep_rw");
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk("unmapped_read_err", 1, e);
    apb(1'b1, 12'h020, 32'h0, r, e);
    chk("unmapped_write_err", 1, e);
    $display("test registers done");
    do_reset();
    for (int i = 0; i < 3; i++) begin
      wr(`WDT_ADDR_CONFIG, {31'h0, i == 1});
      do begin
        key = seed[4:0];
        seed = xs(seed);
      end while (key == `WDT_KEY_ENABLE || key == `WDT_KEY_DISABLE);
      wr(`WDT_ADDR_CONTROL, {24'h0, key, 3'h3});
      wait_pulse(20, n);
      chk("fault_delay", 1, n >= 3 && n <= 16);
      chk("fault_device_reset", 1, deviceReset);
      rd(`WDT_ADDR_CONTROL, 32'hff, 32'h53, "control_after_fault");
      rd(`WDT_ADDR_SYSFLAGS, 32'h1, 32'h1, "fault_flag_set");
    end
    chk("irq_masked", 0, irq);
    wr(`WDT_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq_raised", 1, irq);
    wr(`WDT_ADDR_SYSFLAGS, 32'h1);
    rd(`WDT_ADDR_SYSFLAGS, 32'h1, 32'h1, "flag_write_one");
    wr(`WDT_ADDR_SYSFLAGS, 32'h0);
    rd(`WDT_ADDR_SYSFLAGS, 32'h1, 32'h0, "flag_write_zero");
    wr(`WDT_ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq_cleared", 0, irq);
    $display("test key_fault done");
    run_to("rc_sel0", 3'h2, `WDT_KEY_ENABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    run_to("rc_sel1", 3'h2, `WDT_KEY_ENABLE, 3'h1, 4, keyed_watchdog_pkg::MODE_SLOW, 1, 0);
    run_to("rc_sel2", 3'h2, `WDT_KEY_ENABLE, 3'h2, 4, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    run_to("xtal", 3'h6, `WDT_KEY_ENABLE, 3'h0, 8, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    run_to("sys_div", 3'h0, `WDT_KEY_ENABLE, 3'h0, 16, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    sysSlow <= 1'b1;
    run_to("sys_slow", 3'h0, `WDT_KEY_ENABLE, 3'h0, 32, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    sysSlow <= 1'b0;
    run_to("sleep", 3'h2, `WDT_KEY_ENABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_SLEEP, 1, 0);
    run_to("idle", 3'h2, `WDT_KEY_ENABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_IDLE, 1, 0);
    run_to("disabled", 3'h2, `WDT_KEY_DISABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_RUN, 0, 0);
    run_to("always_on", 3'h3, `WDT_KEY_DISABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_RUN, 1, 0);
    run_to("restart", 3'h2, `WDT_KEY_ENABLE, 3'h0, 4, keyed_watchdog_pkg::MODE_RUN, 1, 700);
    finish_test();
  end
endmodule
